/* File: verilog/mem_strobe_defines.svh */
// Constants for the memory strobe and address output block
`ifndef MEM_STROBE_DEFINES_SVH
`define MEM_STROBE_DEFINES_SVH

// Static bank word address field of the local address
`define ST_ADDR_MSB 13
`define ST_ADDR_LSB 2
// Fewest DRAM column bits; the configured code adds to this
`define DRAM_COL_BASE 4'h8
`define MUX_ADDR_W 12
`define BEAT_W 2
// Idle (deasserted) levels of the active-low strobe groups
`define STATIC_WE_IDLE 4'hF
`define ROW_STROBE_IDLE 4'hF
`define COL_STROBE_IDLE 8'hFF
`define BANK_SEL_IDLE 2'h3
`define DRAM_WE_IDLE 2'h3

`endif

/* File: verilog/mem_strobe_pkg.sv */
// Types shared by the memory strobe and address output block
package mem_strobe_pkg;

    typedef enum logic [1:0] {
        TGT_STATIC0 = 2'h0,
        TGT_STATIC1 = 2'h1,
        TGT_DRAM = 2'h2
    } mem_target_e;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0] byte_lane_enable_n;
        logic write;
        mem_target_e target;
        logic [1:0] beats_m1;
        logic [1:0] dram_bank;
    } mem_req_s;

    typedef struct packed {
        logic interleaved;
        logic [1:0] col_width_code;
    } dram_cfg_s;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_S_SETUP = 4'h1,
        ST_S_STROBE = 4'h3,
        ST_S_HOLD = 4'h2,
        ST_D_ROW = 4'h6,
        ST_D_RAS = 4'h7,
        ST_D_COL = 4'h5,
        ST_D_CAS = 4'h4,
        ST_R_CAS = 4'hC,
        ST_R_RAS = 4'hD,
        ST_R_END = 4'hF
    } seq_state_e;

endpackage : mem_strobe_pkg

/* File: verilog/addr_counter.sv */
// Loadable incrementing address counter
`timescale 1ns/1ps
`default_nettype none

module addr_counter #(
    parameter int W = 12
) (
    input wire logic clk_i,          // System clock
    input wire logic rst_n_i,        // Synchronised reset, active low
    input wire logic load_i,         // Load start address
    input wire logic [W-1:0] load_val_i, // Start address
    input wire logic inc_i,          // Advance by one
    output logic [W-1:0] count_o     // Current address
);

    logic [W-1:0] count_r;
    logic [W-1:0] count_nxt;

    assign count_nxt = load_i ? load_val_i :
                       inc_i ? W'(count_r + 1'b1) : count_r;
    assign count_o = count_r;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

endmodule : addr_counter

`default_nettype wire

/* File: verilog/memory_strobe_address_outputs.sv */
// Memory controller address mux and strobe output sequencer
// Summary of operation
// - Static banks 0/1 put word address bits 13:2 on the muxed address.
// - Static bursts advance the muxed address by one per transfer.
// - DRAM row and column 11:0 are muxed by column width and arrangement.
// - Static write data stays valid across the write strobe rising edge.
// - Static write strobe n asserts only for writes enabling byte lane n.
// - Row strobe asserts only once the row address is on the outputs, or after the column strobes in refresh.
// - Row strobe deasserts after the last transfer of each DRAM access.
// - Row strobe per bank, or strobes 0,2 even and 1,3 odd leaf.
// - Column strobes assert with valid column address and during refresh.
// - One static bank select at a time, held for the whole access.
// - Both DRAM write strobes identical, low for writes, high for reads.
`timescale 1ns/1ps
`default_nettype none
`include "mem_strobe_defines.svh"

module memory_strobe_address_outputs
    import mem_strobe_pkg::*;
(
    input wire logic clk_sys_i,                // 125 MHz system clock
    input wire logic nrst_i,                   // Async reset, active low
    input wire logic req_valid_i,              // Access request present
    input wire mem_req_s req_i,                // Access request fields
    input wire dram_cfg_s cfg_i,               // DRAM arrangement
    input wire logic refresh_req_i,            // Refresh request level
    output logic req_ready_o,                  // Sequencer idle
    output logic xfer_done_o,                  // One pulse per transfer
    output logic [11:0] muxed_mem_addr_o,      // Multiplexed address
    output logic [3:0] static_write_strobe_n_o, // Static write strobes
    output logic [3:0] row_strobe_n_o,         // DRAM row strobes
    output logic [7:0] column_strobe_n_o,      // DRAM column strobes
    output logic [1:0] static_bank_select_n_o, // Static bank selects
    output logic [1:0] dram_write_strobe_n_o,  // DRAM write strobes
    output logic [31:0] local_addr_data_o,     // Write data out
    output logic local_addr_data_oe_o          // Write data drive enable
);

    localparam int AW = `MUX_ADDR_W;

    // ==========================================================
    // Reset release
    // ==========================================================
    logic rst_meta_r;
    logic rst_n_r;

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // ==========================================================
    // Request capture and address mapping
    // ==========================================================
    seq_state_e state_r;
    seq_state_e state_nxt;
    mem_req_s req_r;
    dram_cfg_s cfg_r;
    logic [`BEAT_W-1:0] beats_left_r;

    // Ready gates the take so the cycle after reset release refuses requests
    wire in_idle = (state_r == ST_IDLE) && req_ready_o;
    wire take_refresh = in_idle && refresh_req_i;
    wire take_req = in_idle && req_valid_i && !refresh_req_i;
    wire start_dram = (req_i.target == TGT_DRAM);

    // Mapping uses the request being taken so the counter loads at once
    wire [29:0] word_addr = req_i.addr[31:2];
    // Interleaved: word bit 0 picks the leaf, so columns start above it
    wire [29:0] leaf_word = cfg_i.interleaved ? (word_addr >> 1) : word_addr;
    wire [3:0] col_width = `DRAM_COL_BASE + {2'h0, cfg_i.col_width_code};
    wire [AW-1:0] col_mask = ~(12'hFFF << col_width);
    wire [29:0] row_word = leaf_word >> col_width;
    wire [AW-1:0] col_start = leaf_word[AW-1:0] & col_mask;
    wire [AW-1:0] static_start = req_i.addr[`ST_ADDR_MSB:`ST_ADDR_LSB];
    wire [AW-1:0] load_val = start_dram ? col_start : static_start;

    logic [AW-1:0] row_addr_r;
    logic [AW-1:0] col_mask_r;
    logic leaf_r;

    wire last_beat = (beats_left_r == '0);
    wire beat_end = (state_r == ST_S_HOLD) || (state_r == ST_D_CAS);
    wire addr_inc = beat_end && !last_beat;

    logic [AW-1:0] burst_addr;

    addr_counter #(
        .W(AW)
    ) u_addr_counter (
        .clk_i(clk_sys_i),
        .rst_n_i(rst_n_r),
        .load_i(take_req),
        .load_val_i(load_val),
        .inc_i(addr_inc),
        .count_o(burst_addr)
    );

    always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            req_r <= '0;
            cfg_r <= '0;
            row_addr_r <= '0;
            col_mask_r <= '0;
            leaf_r <= 1'b0;
        end else if (take_req) begin
            req_r <= req_i;
            cfg_r <= cfg_i;
            row_addr_r <= row_word[AW-1:0];
            col_mask_r <= col_mask;
            leaf_r <= word_addr[0];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            beats_left_r <= '0;
        end else if (take_req) begin
            beats_left_r <= req_i.beats_m1;
        end else if (addr_inc) begin
            beats_left_r <= beats_left_r - 1'b1;
        end
    end

    // ==========================================================
    // Sequencer
    // ==========================================================
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (take_refresh) begin
                    state_nxt = ST_R_CAS;
                end else if (take_req) begin
                    state_nxt = start_dram ? ST_D_ROW : ST_S_SETUP;
                end
            end
            ST_S_SETUP: state_nxt = ST_S_STROBE;
            ST_S_STROBE: state_nxt = ST_S_HOLD;
            // strobe released one cycle before data changes
            ST_S_HOLD: state_nxt = last_beat ? ST_IDLE : ST_S_SETUP;
            ST_D_ROW: state_nxt = ST_D_RAS;
            ST_D_RAS: state_nxt = ST_D_COL;
            ST_D_COL: state_nxt = ST_D_CAS;
            // leave row strobe active only until the last transfer
            ST_D_CAS: state_nxt = last_beat ? ST_IDLE : ST_D_COL;
            ST_R_CAS: state_nxt = ST_R_RAS;
            ST_R_RAS: state_nxt = ST_R_END;
            ST_R_END: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ==========================================================
    // Output decode
    // ==========================================================
    wire st_static = (state_r == ST_S_SETUP) || (state_r == ST_S_STROBE) ||
                     (state_r == ST_S_HOLD);
    wire st_row_phase = (state_r == ST_D_ROW) || (state_r == ST_D_RAS);
    wire st_dram = st_row_phase || (state_r == ST_D_COL) ||
                   (state_r == ST_D_CAS);
    wire st_refresh = (state_r == ST_R_CAS) || (state_r == ST_R_RAS);
    // row strobe only after a cycle of stable row address
    wire ras_on = (state_r == ST_D_RAS) || (state_r == ST_D_COL) ||
                  (state_r == ST_D_CAS);

    // row during row phase, masked column counter afterwards
    wire [AW-1:0] mux_addr = st_row_phase ? row_addr_r :
                             st_dram ? (burst_addr & col_mask_r) :
                             burst_addr;

    // lane strobes follow the byte enables on writes only
    wire [3:0] mwe_n = (state_r == ST_S_STROBE && req_r.write) ?
                       req_r.byte_lane_enable_n : `STATIC_WE_IDLE;

    // bank number, or bank pair plus leaf when interleaved
    wire [1:0] ras_idx = cfg_r.interleaved ? {req_r.dram_bank[1], leaf_r} :
                         req_r.dram_bank;
    wire [3:0] ras_sel = 4'h1 << ras_idx;
    // Refresh hits every bank; CAS leads RAS for CAS-before-RAS refresh
    wire [3:0] ras_n = (state_r == ST_R_RAS) ? 4'h0 :
                       ras_on ? ~ras_sel : `ROW_STROBE_IDLE;

    // Interleaved bursts stay in one leaf; the other leaf needs its own
    // access, which keeps the column counter simple
    wire [7:0] cas_lanes = cfg_r.interleaved ?
        (leaf_r ? {~req_r.byte_lane_enable_n, 4'h0} :
                  {4'h0, ~req_r.byte_lane_enable_n}) :
        {~req_r.byte_lane_enable_n, ~req_r.byte_lane_enable_n};
    // column strobes on column address and in refresh
    wire [7:0] cas_n = st_refresh ? 8'h00 :
                       (state_r == ST_D_CAS) ? ~cas_lanes :
                       `COL_STROBE_IDLE;

    // exactly one bank select, held over all static states
    wire [1:0] ce_n = !st_static ? `BANK_SEL_IDLE :
                      (req_r.target == TGT_STATIC1) ? 2'h1 : 2'h2;

    wire dwe_on = ras_on && req_r.write;
    wire [1:0] dwe_n = dwe_on ? 2'h0 : `DRAM_WE_IDLE;

    // data driven over the whole write, past the strobe edge
    wire data_oe = (st_static || st_dram) && req_r.write;

    // ==========================================================
    // Output registers
    // ==========================================================
    always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            req_ready_o <= 1'b0;
            xfer_done_o <= 1'b0;
            muxed_mem_addr_o <= '0;
            static_write_strobe_n_o <= `STATIC_WE_IDLE;
            row_strobe_n_o <= `ROW_STROBE_IDLE;
            column_strobe_n_o <= `COL_STROBE_IDLE;
            static_bank_select_n_o <= `BANK_SEL_IDLE;
            dram_write_strobe_n_o <= `DRAM_WE_IDLE;
            local_addr_data_o <= '0;
            local_addr_data_oe_o <= 1'b0;
        end else begin
            req_ready_o <= (state_nxt == ST_IDLE);
            xfer_done_o <= beat_end;
            muxed_mem_addr_o <= mux_addr;
            static_write_strobe_n_o <= mwe_n;
            row_strobe_n_o <= ras_n;
            column_strobe_n_o <= cas_n;
            static_bank_select_n_o <= ce_n;
            dram_write_strobe_n_o <= dwe_n;
            local_addr_data_o <= req_r.wdata;
            local_addr_data_oe_o <= data_oe;
        end
    end

endmodule : memory_strobe_address_outputs

`default_nettype wire

/* File: dv/mem_strobe_sva.sv */
// Assertion checker for the memory strobe and address outputs
`timescale 1ns/1ps
`default_nettype none

module mem_strobe_sva
    import mem_strobe_pkg::*;
(
    input wire logic clk_sys_i, // Clock
    input wire logic nrst_i, // Reset, active low
    input wire logic req_valid_i, // Request
    input wire mem_req_s req_i, // Request fields
    input wire dram_cfg_s cfg_i, // DRAM setup
    input wire logic refresh_req_i, // Refresh
    input wire logic req_ready_o, // Idle
    input wire logic xfer_done_o, // Transfer
    input wire logic [11:0] muxed_mem_addr_o, // Address
    input wire logic [3:0] static_write_strobe_n_o, // Static strobes
    input wire logic [3:0] row_strobe_n_o, // Row strobes
    input wire logic [7:0] column_strobe_n_o, // Column strobes
    input wire logic [1:0] static_bank_select_n_o, // Bank selects
    input wire logic [1:0] dram_write_strobe_n_o, // DRAM strobes
    input wire logic [31:0] local_addr_data_o, // Write data
    input wire logic local_addr_data_oe_o // Data enable
);
    wire logic no_ras = &row_strobe_n_o;
    wire logic no_cas = &column_strobe_n_o;
    wire logic no_ce = &static_bank_select_n_o;
    wire logic no_mwe = &static_write_strobe_n_o;
    wire logic take = req_valid_i && req_ready_o && !refresh_req_i;

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    // ====================================
    // Output relations
    sel_excl_a: assert property (static_bank_select_n_o != 2'h0)
        else $error("both bank selects low");
    st_addr_a: assert property (take && req_i.target != TGT_DRAM |=> ##1
        muxed_mem_addr_o == $past(req_i.addr[13:2], 2) && !no_ce)
        else $error("static address wrong");
    burst_inc_a: assert property (xfer_done_o && !no_ce ##1 !no_ce |->
        muxed_mem_addr_o == $past(muxed_mem_addr_o) + 12'h1)
        else $error("burst address not advanced");
    data_hold_a: assert property ($rose(no_mwe) |->
        $stable(local_addr_data_o) && local_addr_data_oe_o)
        else $error("data moved at strobe rise");
    mwe_ctx_a: assert property (!no_mwe |-> !no_ce && no_ras)
        else $error("static strobe outside static write");
    ras_row_a: assert property ($fell(no_ras) && no_cas |->
        $stable(muxed_mem_addr_o))
        else $error("row strobe before row address");
    ras_end_a: assert property ($fell(no_ras) && no_cas |->
        ##[1:10] no_ras)
        else $error("row strobe not released");
    cas_col_a: assert property ($fell(no_cas) && !no_ras |->
        $stable(muxed_mem_addr_o))
        else $error("column strobe before column address");
    refresh_seq_a: assert property (refresh_req_i && req_ready_o |=>
        ##1 column_strobe_n_o == 8'h00 ##1 row_strobe_n_o == 4'h0)
        else $error("refresh strobes wrong");
    dwe_pair_a: assert property (
        dram_write_strobe_n_o inside {2'h0, 2'h3} &&
        (dram_write_strobe_n_o[0] || !no_ras))
        else $error("DRAM write strobes wrong");
endmodule : mem_strobe_sva

bind memory_strobe_address_outputs mem_strobe_sva u_sva (.*);

`default_nettype wire

/* File: dv/mem_device_model.sv */
// Write-capture model of the static memory behind the strobes
`timescale 1ns/1ps
`default_nettype none

module mem_device_model (
    input wire logic [3:0] we_n_i, // Write strobes, active low
    input wire logic [31:0] data_i, // Write data
    input wire logic oe_i, // Controller drives the data bus
    output logic [31:0] cap_o // Last stored word
);
    logic [31:0] cap = 32'h0;
    logic [3:0] we_q = 4'hF;

    assign cap_o = cap;

    // Each byte latches at the rising edge of its own strobe, as the
    // memory does; an undriven bus stores unknown data
    always @(we_n_i) begin
        for (int i = 0; i < 4; i++) begin
            if (!we_q[i] && we_n_i[i])
                cap[8*i+:8] = oe_i ? data_i[8*i+:8] : {8{1'bx}};
        end
        we_q = we_n_i;
    end
endmodule : mem_device_model

`default_nettype wire

/* File: dv/memory_strobe_address_outputs_tb_top.sv */
// Self-checking bench for the memory strobe and address outputs
`timescale 1ns/1ps
`default_nettype none

module memory_strobe_address_outputs_tb_top
    import mem_strobe_pkg::*;
;
    logic clk_sys_i, nrst_i, req_valid_i, refresh_req_i;
    mem_req_s req_i;
    dram_cfg_s cfg_i;
    logic req_ready_o, xfer_done_o, local_addr_data_oe_o;
    logic [11:0] muxed_mem_addr_o, a_first, a_col;
    logic [3:0] static_write_strobe_n_o, row_strobe_n_o, mwe, ras;
    logic [7:0] column_strobe_n_o, cas;
    logic [1:0] static_bank_select_n_o, dram_write_strobe_n_o, ce, dwe;
    logic [31:0] local_addr_data_o, cap;
    int failures, samples_checked, beats;

    memory_strobe_address_outputs u_dut (.*);
    mem_device_model u_mem (
        .we_n_i(static_write_strobe_n_o),
        .data_i(local_addr_data_o),
        .oe_i(local_addr_data_oe_o),
        .cap_o(cap)
    );

    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    // ====================================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic report_and_stop();
        if (failures == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    task automatic bound(input int n);
        if (n > 30) begin
            failures++;
            report_and_stop();
        end
    endtask : bound

    // Present one request and fold every strobe seen until idle again
    task automatic run(input logic [31:0] a, input logic [3:0] be,
        input logic wr, input mem_target_e t, input logic [1:0] bm,
        input logic [1:0] bk, input logic rf);
        logic fin;
        req_i = {a, 32'hA1B2_C3D4, be, wr, t, bm, bk};
        req_valid_i = 1'b1;
        refresh_req_i = rf;
        {mwe, ras, cas, ce, dwe} = '1;
        a_first = 'x;
        a_col = 'x;
        beats = 0;
        @(negedge clk_sys_i);
        req_valid_i = 1'b0;
        refresh_req_i = 1'b0;
        fin = 1'b0;
        // Ready rises with the last transfer's outputs, so fold that cycle too
        for (int n = 0; !fin; n++) begin
            if (&{ce, ras} && !(&{static_bank_select_n_o, row_strobe_n_o}))
                a_first = muxed_mem_addr_o;
            if (&cas && !(&column_strobe_n_o)) a_col = muxed_mem_addr_o;
            beats += xfer_done_o;
            mwe &= static_write_strobe_n_o;
            ras &= row_strobe_n_o;
            cas &= column_strobe_n_o;
            ce &= static_bank_select_n_o;
            dwe &= dram_write_strobe_n_o;
            fin = (req_ready_o === 1'b1);
            bound(n);
            if (!fin) @(negedge clk_sys_i);
        end
    endtask : run

    // ====================================
    // Scenarios
    // Four-beat bank 0 write whose word address wraps past 12 bits
    task automatic sc_static_wr();
        run(32'h0000_3FF8, 4'hA, 1'b1, TGT_STATIC0, 2'h3, 2'h0, 1'b0);
        chk(a_first, 32'hFFE);
        chk(mwe, 4'hA);
        chk(cap, 32'h00B2_00D4);
        chk(ce, 2'h2);
        chk(beats, 4);
        chk({ras, dwe}, 6'h3F);
    endtask : sc_static_wr

    // Bank 1 read with high address bits set; memory must stay untouched
    task automatic sc_static_rd();
        run(32'hFFFF_C004, 4'h0, 1'b0, TGT_STATIC1, 2'h0, 2'h0, 1'b0);
        chk(a_first, 32'h001);
        chk(mwe, 4'hF);
        chk(ce, 2'h1);
        chk(cap, 32'h00B2_00D4);
    endtask : sc_static_rd

    // Every bank and column width, plain writes then interleaved reads
    task automatic sc_dram();
        logic [31:0] w;
        logic [1:0] bk;
        logic [1:0] ix;
        for (int i = 0; i < 8; i++) begin
            cfg_i = {i[2], i[1:0]};
            bk = i[1:0] ^ {1'b0, i[2]};
            run(32'h0123_4568 + 4 * i, 4'h5, !i[2], TGT_DRAM, i[1:0], bk,
                1'b0);
            w = (32'h0123_4568 + 4 * i) >> (2 + i[2]);
            ix = i[2] ? {bk[1], i[0]} : bk;
            chk(ras, {~(4'h1 << ix)});
            chk(a_first, (w >> (8 + i[1:0])) & 32'hFFF);
            chk(a_col, w & ((32'h1 << (8 + i[1:0])) - 1) & 32'hFFF);
            chk(cas, i[2] ? (i[0] ? 8'h5F : 8'hF5) : 8'h55);
            chk(dwe, i[2] ? 2'h3 : 2'h0);
            chk(beats, i[1:0] + 1);
            chk({ce, mwe}, 6'h3F);
        end
    endtask : sc_dram

    // Refresh raised with a write request pending: refresh wins
    task automatic sc_refresh();
        run(32'h0, 4'h0, 1'b1, TGT_STATIC0, 2'h0, 2'h0, 1'b1);
        chk({cas, ras}, 12'h000);
        chk({mwe, ce, dwe}, 8'hFF);
    endtask : sc_refresh

    initial begin
        failures = 0;
        samples_checked = 0;
        nrst_i = 1'b0;
        req_valid_i = 1'b0;
        refresh_req_i = 1'b0;
        req_i = '0;
        cfg_i = '0;
        repeat (12) @(negedge clk_sys_i);
        nrst_i = 1'b1;
        for (int n = 0; req_ready_o !== 1'b1; n++) begin
            bound(n);
            @(negedge clk_sys_i);
        end
        sc_static_wr();
        sc_static_rd();
        sc_dram();
        sc_refresh();
        report_and_stop();
    end
endmodule : memory_strobe_address_outputs_tb_top

`default_nettype wire
